// File: bit_sync.sv
// Two-flip-flop level synchroniser for a group of independent bits.
// Assumes each input bit is a flip-flop output of another clock domain.
`timescale 1ns/10ps

module bit_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clock,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_regs_type;

  sync_regs_type regs;
  sync_regs_type next_regs;

  generate
    if (WIDTH < 1)
    begin : g_check
      $error("bit_sync needs at least one bit");
    end
  endgenerate

  // The first stage feeds only the second stage.
  always_comb
  begin
    next_regs.meta = d;
    next_regs.sync = regs.meta;
  end

  always_ff @(posedge clock)
  begin
    regs <= next_regs;
  end

  assign q = regs.sync;

endmodule

// File: cfg_map.svh
// Constants for the test-port configuration frame path: widths, opcodes and reset values.
// Assumes nothing; included by the top-level design file and by the testbench, not by the package.
`ifndef CFG_MAP_SVH
`define CFG_MAP_SVH

`define IR_WIDTH          23
`define FRAME_WIDTH       128
`define ID_WIDTH          32
`define READ_DR_WIDTH     129
`define STRAP_WIDTH       2
`define OP_BYPASS         23'h00_0000
`define OP_DEVICE_ID      23'h7f_fffe
`define OP_CFG_WRITE      23'h00_0010
`define OP_CFG_READ       23'h00_0011
`define OP_UNLOCK         23'h00_0012
`define IR_CAPTURE        23'h00_0001
// Identification value is arbitrary; its lowest bit is one as the scan convention demands.
`define DEVICE_ID_DEFAULT 32'h1234_5677

`endif

// File: cfg_pkg.sv
// Types shared by the test-port configuration frame path.
// Assumes nothing; cfg_map.svh is not included here.
package cfg_pkg;

  typedef enum logic [3:0] {
    test_logic_reset, run_test_idle,
    select_dr_scan, capture_dr, shift_dr, exit1_dr, pause_dr, exit2_dr, update_dr,
    select_ir_scan, capture_ir, shift_ir, exit1_ir, pause_ir, exit2_ir, update_ir
  } tap_state_type;

  typedef enum logic [2:0] {
    sel_bypass, sel_id, sel_write, sel_read, sel_unlock
  } dr_select_type;

endpackage

// File: frame_handshake.sv
// Toggle handshake that carries one word at a time between two clock domains.
// Assumes the source holds nothing else on src_data; the word register stays stable until
// the far side returns the acknowledge toggle.
`timescale 1ns/10ps

module frame_handshake
#(
  parameter int WIDTH = 128
)
(
  input  wire logic             src_clock,
  input  wire logic             src_rst,
  input  wire logic             src_valid,
  input  wire logic [WIDTH-1:0] src_data,
  output logic                  src_busy,
  input  wire logic             dst_clock,
  input  wire logic             dst_rst,
  input  wire logic             dst_ready,
  output logic                  dst_valid,
  output logic      [WIDTH-1:0] dst_data
);

  typedef struct packed {
    logic             req;
    logic [WIDTH-1:0] data;
  } src_regs_type;

  typedef struct packed {
    logic             seen;
    logic             pending;
    logic             ack;
    logic [WIDTH-1:0] data;
  } dst_regs_type;

  src_regs_type src;
  src_regs_type next_src;
  dst_regs_type dst;
  dst_regs_type next_dst;
  logic         ack_s;
  logic         req_s;

  generate
    if (WIDTH < 1)
    begin : g_check
      $error("frame_handshake needs at least one bit");
    end
  endgenerate

  bit_sync #(.WIDTH(1)) u_ack_sync (.clock(src_clock), .d(dst.ack), .q(ack_s));
  bit_sync #(.WIDTH(1)) u_req_sync (.clock(dst_clock), .d(src.req), .q(req_s));

  // Busy while a word is in flight, so a new word never overwrites an unanswered one.
  assign src_busy = src.req ^ ack_s;

  always_comb
  begin
    next_src = src;
    if (src_valid && !src_busy)
    begin
      next_src.data = src_data;
      next_src.req  = ~src.req;
    end
  end

  always_ff @(posedge src_clock)
  begin
    if (src_rst)
      src <= '0;
    else
      src <= next_src;
  end

  // The acknowledge toggles back only once the consumer has taken the word.
  always_comb
  begin
    next_dst = dst;
    if (!dst.pending && (req_s != dst.seen))
    begin
      next_dst.seen    = req_s;
      next_dst.data    = src.data;
      next_dst.pending = 1'b1;
    end
    if (dst.pending && dst_ready)
    begin
      next_dst.pending = 1'b0;
      next_dst.ack     = ~dst.ack;
    end
  end

  always_ff @(posedge dst_clock)
  begin
    if (dst_rst)
      dst <= '0;
    else
      dst <= next_dst;
  end

  assign dst_valid = dst.pending;
  assign dst_data  = dst.data;

endmodule

// File: jtag_config_frame_path.sv
// Test access port and the frame path that joins it to the configuration unit.
// Assumes tck comes from the test host and may stop between scans; clock is the
// configuration unit's clock; trst_n is sampled on tck and rst on clock.
`timescale 1ns/10ps
`include "cfg_map.svh"

//////////////////////////////////////////////////////////////////////////////////////////////////

// Summary of operation
// R1: Mode select and test data in are sampled on the rising test clock edge.
// R2: Test data out changes on the falling test clock edge.
// R3: Mode select level steers the controller into instruction or data scans.
// R4: The controller follows the standard sixteen-state boundary-scan diagram.
// R5: Test-port configuration works whatever the configuration mode straps say.
// R6: Five test pins connect straight to the controller without other logic.
// R7: The controller is always active, clocked only by the test clock.
// R8: Shifted data becomes frame commands; read requests become shifted-out data.
// R9: Write scans produce 128-bit frames with a valid strobe toward the multiplexer.
// R10: The multiplexer accepts 128-bit read-back frames with a valid signal.
// R11: The multiplexer acknowledges each successfully completed transfer.
// R12: Straps pick the frame source; the test-port override takes precedence.
// R13: Frames flow to the configuration engine; read-back frames flow toward the port.
// R14: With the lock option set, the unit locks after programming and refuses access.
// R15: Unlock requests are ignored while the loaded bitstream is encrypted.
// R16: The host skips the reset step when a configuration is already held; the testbench always runs reset_tap once at start.
// R17: Reset or test-logic-reset selects the 32-bit identification register.
// R18: The all-zero 23-bit instruction selects the single-bit bypass register.
// R19: Frames, strobes and acknowledges cross clock domains by a safe handshake.
// R20: One acknowledge cycle per frame; no new frame until the previous is acknowledged.
module jtag_config_frame_path
  import cfg_pkg::*;
#(
  parameter int                   SOURCES   = 4,
  parameter logic [`ID_WIDTH-1:0] DEVICE_ID = `DEVICE_ID_DEFAULT
)
(
  input  wire logic                            clock,
  input  wire logic                            rst,
  input  wire logic                            tck,
  input  wire logic                            trst_n,
  input  wire logic                            tms,
  input  wire logic                            tdi,
  output logic                                 tdo,
  output logic                                 tdo_oe,
  input  wire logic [`STRAP_WIDTH-1:0]         config_mode_straps,
  input  wire logic [SOURCES*`FRAME_WIDTH-1:0] src_frame,
  input  wire logic [SOURCES-1:0]              src_valid,
  output logic      [SOURCES-1:0]              src_ack,
  output logic      [`FRAME_WIDTH-1:0]         cfg_in_frame,
  output logic                                 cfg_in_valid,
  input  wire logic                            cfg_in_ready,
  input  wire logic [`FRAME_WIDTH-1:0]         rd_frame,
  input  wire logic                            rd_valid,
  output logic                                 rd_ack,
  input  wire logic                            lock_option,
  input  wire logic                            bitstream_encrypted,
  input  wire logic                            program_done,
  output logic                                 locked,
  output logic                                 jtag_override
);

  localparam int IRW = `IR_WIDTH;
  localparam int FW  = `FRAME_WIDTH;
  localparam int RDW = `READ_DR_WIDTH;
  localparam int SW  = `STRAP_WIDTH;

  generate
    if (SOURCES < 1 || SOURCES > (1 << SW))
    begin : g_check
      $error("SOURCES must lie between one and the number of strap codes");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Decoding shared by capture, shift and update.

  function automatic dr_select_type dr_select(input logic [IRW-1:0] ir);
    dr_select_type sel;
    sel = sel_bypass;
    if (ir == `OP_DEVICE_ID)
      sel = sel_id;
    else if (ir == `OP_CFG_WRITE)
      sel = sel_write;
    else if (ir == `OP_CFG_READ)
      sel = sel_read;
    else if (ir == `OP_UNLOCK)
      sel = sel_unlock;
    return sel;
  endfunction

  function automatic int dr_length(input dr_select_type sel);
    int len;
    len = 1;
    unique case (sel)
      sel_id:     len = `ID_WIDTH;
      sel_write:  len = FW;
      sel_read:   len = RDW;
      sel_bypass,
      sel_unlock: len = 1;
    endcase
    return len;
  endfunction

  function automatic tap_state_type tap_next(input tap_state_type s, input logic m);
    tap_state_type n;
    n = s;
    unique case (s)
      test_logic_reset: n = m ? test_logic_reset : run_test_idle;
      run_test_idle:    n = m ? select_dr_scan : run_test_idle;
      select_dr_scan:   n = m ? select_ir_scan : capture_dr;
      capture_dr:       n = m ? exit1_dr : shift_dr;
      shift_dr:         n = m ? exit1_dr : shift_dr;
      exit1_dr:         n = m ? update_dr : pause_dr;
      pause_dr:         n = m ? exit2_dr : pause_dr;
      exit2_dr:         n = m ? update_dr : shift_dr;
      update_dr:        n = m ? select_dr_scan : run_test_idle;
      select_ir_scan:   n = m ? test_logic_reset : capture_ir;
      capture_ir:       n = m ? exit1_ir : shift_ir;
      shift_ir:         n = m ? exit1_ir : shift_ir;
      exit1_ir:         n = m ? update_ir : pause_ir;
      pause_ir:         n = m ? exit2_ir : pause_ir;
      exit2_ir:         n = m ? update_ir : shift_ir;
      update_ir:        n = m ? select_dr_scan : run_test_idle;
    endcase
    return n;
  endfunction

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Test-clock domain: the access port controller.

  typedef struct packed {
    tap_state_type  state;
    logic [IRW-1:0] ir;
    logic [IRW-1:0] ir_shift;
    logic [RDW-1:0] dr_shift;
    logic           override;
    logic           unlock_toggle;
  } tap_regs_type;

  localparam tap_regs_type TAP_RESET = '{
    state:         test_logic_reset,
    ir:            `OP_DEVICE_ID,
    ir_shift:      '0,
    dr_shift:      '0,
    override:      1'b0,
    unlock_toggle: 1'b0
  };

  tap_regs_type   tap;
  tap_regs_type   next_tap;
  dr_select_type  sel;
  int             dr_len;
  logic           test_rst;
  logic [RDW-1:0] dr_shifted;
  logic           wr_send;
  logic           wr_busy;
  logic           rd_take;
  logic           rd_tck_valid;
  logic [FW-1:0]  rd_tck_frame;

  assign test_rst   = ~trst_n;
  assign sel        = dr_select(tap.ir);
  assign dr_len     = dr_length(sel);
  assign dr_shifted = {1'b0, tap.dr_shift[RDW-1:1]};
  assign wr_send    = (tap.state == update_dr) && (sel == sel_write);  // R9
  assign rd_take    = (tap.state == capture_dr) && (sel == sel_read);  // R13

  always_comb
  begin
    next_tap       = tap;
    next_tap.state = tap_next(tap.state, tms);  // R3 R4
    unique case (tap.state)
      test_logic_reset:
        next_tap.ir = `OP_DEVICE_ID;  // R17
      capture_ir:
        next_tap.ir_shift = `IR_CAPTURE;
      shift_ir:
        next_tap.ir_shift = {tdi, tap.ir_shift[IRW-1:1]};  // R1
      update_ir:
        next_tap.ir = tap.ir_shift;
      capture_dr:
      begin
        next_tap.dr_shift = '0;  // R18
        unique case (sel)
          sel_id:
            next_tap.dr_shift[`ID_WIDTH-1:0] = DEVICE_ID;  // R17
          sel_write:
            next_tap.dr_shift[0] = wr_busy;
          sel_read:
            next_tap.dr_shift = rd_tck_valid ? {rd_tck_frame, 1'b1} : '0;  // R8
          sel_bypass,
          sel_unlock:
            next_tap.dr_shift[0] = 1'b0;
        endcase
      end
      shift_dr:
      begin
        for (int i = 0; i < RDW; i++)
        begin
          if (i == dr_len - 1)
            next_tap.dr_shift[i] = tdi;  // R1 R8
          else if (i < dr_len - 1)
            next_tap.dr_shift[i] = dr_shifted[i];
          else
            next_tap.dr_shift[i] = 1'b0;
        end
      end
      update_dr:
      begin
        if (sel == sel_unlock)
          next_tap.unlock_toggle = ~tap.unlock_toggle;
      end
      run_test_idle, select_dr_scan, exit1_dr, pause_dr, exit2_dr,
      select_ir_scan, exit1_ir, pause_ir, exit2_ir:
        next_tap.ir = tap.ir;
    endcase
    next_tap.override = (next_tap.ir == `OP_CFG_WRITE);  // R12
  end

  // Runs on the test clock alone, whatever the configuration unit is doing.
  always_ff @(posedge tck)
  begin
    if (test_rst)
      tap <= TAP_RESET;  // R7 R17
    else
      tap <= next_tap;  // R1 R6
  end

  // Output stage on the falling edge so the host samples a settled bit on the next rise.
  always_ff @(negedge tck)
  begin
    if (test_rst)
    begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else
    begin
      tdo    <= (tap.state == shift_ir) ? tap.ir_shift[0] : tap.dr_shift[0];  // R2
      tdo_oe <= (tap.state == shift_ir) || (tap.state == shift_dr);  // R2
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Crossings between the two domains.

  logic          wr_cfg_valid;
  logic [FW-1:0] wr_cfg_frame;
  logic          jtag_take;
  logic          rd_busy;
  logic          override_s;
  logic          unlock_s;
  logic [SW-1:0] straps_s;

  frame_handshake #(.WIDTH(FW)) u_write_path (  // R19
    .src_clock (tck),
    .src_rst   (test_rst),
    .src_valid (wr_send),
    .src_data  (tap.dr_shift[FW-1:0]),
    .src_busy  (wr_busy),
    .dst_clock (clock),
    .dst_rst   (rst),
    .dst_ready (jtag_take),
    .dst_valid (wr_cfg_valid),
    .dst_data  (wr_cfg_frame)
  );

  frame_handshake #(.WIDTH(FW)) u_read_path (  // R19
    .src_clock (clock),
    .src_rst   (rst),
    .src_valid (rd_valid && !locked),
    .src_data  (rd_frame),
    .src_busy  (rd_busy),
    .dst_clock (tck),
    .dst_rst   (test_rst),
    .dst_ready (rd_take),
    .dst_valid (rd_tck_valid),
    .dst_data  (rd_tck_frame)
  );

  bit_sync #(.WIDTH(2)) u_level_sync (
    .clock (clock),
    .d     ({tap.override, tap.unlock_toggle}),
    .q     ({override_s, unlock_s})
  );

  bit_sync #(.WIDTH(SW)) u_strap_sync (
    .clock (clock),
    .d     (config_mode_straps),
    .q     (straps_s)
  );

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Configuration-clock domain: source multiplexer, lock and read-back return.

  typedef struct packed {
    logic [SW-1:0] straps;
    logic [FW-1:0] frame;
    logic          valid;
    logic          locked;
    logic          done_seen;
    logic          unlock_seen;
  } cfg_regs_type;

  cfg_regs_type cfg;
  cfg_regs_type next_cfg;
  int           strap_index;
  logic         done_rise;
  logic         unlock_event;

  assign strap_index  = int'(cfg.straps);
  assign done_rise    = program_done && !cfg.done_seen;
  assign unlock_event = unlock_s != cfg.unlock_seen;

  always_comb
  begin
    next_cfg             = cfg;
    src_ack              = '0;
    jtag_take            = 1'b0;
    next_cfg.done_seen   = program_done;
    next_cfg.unlock_seen = unlock_s;
    if (cfg.valid && cfg_in_ready)
      next_cfg.valid = 1'b0;  // R13
    if (!cfg.valid)
    begin
      if (override_s)
      begin
        if (wr_cfg_valid)
        begin
          jtag_take = 1'b1;  // R20
          if (!cfg.locked)
          begin
            next_cfg.frame = wr_cfg_frame;  // R5 R12
            next_cfg.valid = 1'b1;  // R9
          end
        end
      end
      else if (strap_index < SOURCES)
      begin
        if (src_valid[strap_index])
        begin
          next_cfg.frame        = src_frame[strap_index*FW +: FW];  // R12
          next_cfg.valid        = 1'b1;
          src_ack[strap_index]  = 1'b1;  // R11 R20
        end
      end
    end
    if (done_rise && lock_option)
      next_cfg.locked = 1'b1;  // R14
    else if (unlock_event && !bitstream_encrypted)
      next_cfg.locked = 1'b0;  // R15
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cfg        <= '0;
      cfg.straps <= straps_s;
    end
    else
    begin
      cfg <= next_cfg;
    end
  end

  // Read-back frames are consumed once the crossing takes them; while locked they are dropped.
  assign rd_ack        = rd_valid && (locked || !rd_busy);  // R10 R11 R14 R20
  assign cfg_in_frame  = cfg.frame;
  assign cfg_in_valid  = cfg.valid;
  assign locked        = cfg.locked;
  assign jtag_override = override_s;

endmodule

// File: jtag_config_frame_path_chk.sv
// Concurrent checks on the ports of the test-port configuration frame path.
// Assumes it is bound to the top module with the same SOURCES value.
`timescale 1ns/10ps

module jtag_config_frame_path_chk
  import cfg_pkg::*;
#(
  parameter int SOURCES = 4
)
(
  input wire logic                clock,
  input wire logic                rst,
  input wire logic                tck,
  input wire logic                trst_n,
  input wire logic                tdo,
  input wire logic [SOURCES-1:0]  src_valid,
  input wire logic [SOURCES-1:0]  src_ack,
  input wire logic [127:0]        cfg_in_frame,
  input wire logic                cfg_in_valid,
  input wire logic                cfg_in_ready,
  input wire logic                rd_valid,
  input wire logic                rd_ack,
  input wire logic                lock_option,
  input wire logic                bitstream_encrypted,
  input wire logic                program_done,
  input wire logic                locked,
  input wire logic                jtag_override
);
  logic tdo_at_rise;

  always_ff @(posedge tck)
    tdo_at_rise <= tdo;

  sequence take_s;
    |src_ack;
  endsequence

  sequence stall_s;
    cfg_in_valid && !cfg_in_ready;
  endsequence

  property hold_p;
    @(posedge clock) disable iff (rst) stall_s |=> cfg_in_valid && $stable(cfg_in_frame);
  endproperty

  src_take_a:
    assert property (@(posedge clock) disable iff (rst) take_s |=> cfg_in_valid)
    else $error("source taken without frame valid");
  src_cause_a:
    assert property (@(posedge clock) disable iff (rst)
      take_s |-> !cfg_in_valid && (src_ack & ~src_valid) == '0 && $onehot(src_ack))
    else $error("source acknowledge without cause");
  frame_hold_a:
    assert property (hold_p)
    else $error("frame changed before acceptance");
  frame_drop_a:
    assert property (@(posedge clock) disable iff (rst)
      cfg_in_valid && cfg_in_ready |=> !cfg_in_valid)
    else $error("frame valid stayed after acceptance");
  override_wins_a:
    assert property (@(posedge clock) disable iff (rst) jtag_override |-> src_ack == '0)
    else $error("strap source taken under override");
  rd_ack_cause_a:
    assert property (@(posedge clock) disable iff (rst) rd_ack |-> rd_valid)
    else $error("read acknowledge without frame");
  lock_set_a:
    assert property (@(posedge clock) disable iff (rst)
      lock_option && $rose(program_done) |=> locked)
    else $error("lock not set after programming");
  lock_keep_a:
    assert property (@(posedge clock) disable iff (rst)
      locked && bitstream_encrypted |=> locked)
    else $error("encrypted lock released");
  tdo_fall_a:
    assert property (@(negedge tck) disable iff (!trst_n) tdo == tdo_at_rise)
    else $error("test data out moved on rising edge");
endmodule

// File: jtag_config_frame_path_tb.sv
// Self-checking testbench for the test-port configuration frame path.
// Assumes the host model and the checker are compiled before this file.
`timescale 1ns/10ps
`include "cfg_map.svh"

module jtag_config_frame_path_tb;
  import cfg_pkg::*;

  localparam int                   SRC = 4;
  // Arbitrary identification value.
  localparam logic [`ID_WIDTH-1:0] ID  = 32'h5a5a_c3c3;

  logic                        clock, rst, tck, trst_n, tms, tdi, tdo, tdo_oe;
  logic [`STRAP_WIDTH-1:0]     config_mode_straps;
  logic [SRC*`FRAME_WIDTH-1:0] src_frame;
  logic [SRC-1:0]              src_valid, src_ack;
  logic [`FRAME_WIDTH-1:0]     cfg_in_frame, rd_frame, frame;
  logic                        cfg_in_valid, cfg_in_ready, rd_valid, rd_ack, locked;
  logic                        lock_option, bitstream_encrypted, program_done, jtag_override;
  logic [`READ_DR_WIDTH-1:0]   dout;
  logic [`FRAME_WIDTH-1:0]     exp_q[$];
  int                          error_cnt = 0;
  int                          samples_checked = 0;
  int                          oe_cnt = 0;

  jtag_config_frame_path #(.SOURCES(SRC), .DEVICE_ID(ID)) i_jtag_config_frame_path (
    .clock(clock), .rst(rst), .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .config_mode_straps(config_mode_straps),
    .src_frame(src_frame), .src_valid(src_valid), .src_ack(src_ack),
    .cfg_in_frame(cfg_in_frame), .cfg_in_valid(cfg_in_valid), .cfg_in_ready(cfg_in_ready),
    .rd_frame(rd_frame), .rd_valid(rd_valid), .rd_ack(rd_ack), .lock_option(lock_option),
    .bitstream_encrypted(bitstream_encrypted), .program_done(program_done),
    .locked(locked), .jtag_override(jtag_override));

  jtag_host_model i_jtag_host_model (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic check(input logic [128:0] seen, input logic [128:0] want, input string what);
    samples_checked++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d, comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Waits for a source take, a read take or an empty frame queue.
  task automatic wait_for(input int sel);
    for (int n = 0; n < 200; n++)
    begin
      @(posedge clock);
      if ((sel == 0 && src_ack[1] === 1'b1) || (sel == 1 && rd_ack === 1'b1) ||
          (sel == 2 && exp_q.size() == 0))
        return;
    end
    error_cnt++;
    $display("[FAIL] %0t wait ran out", $time);
    report_and_stop;
  endtask

  // Counts test clock rises at which the output enable stands high.
  always @(posedge tck)
    if (tdo_oe === 1'b1)
      oe_cnt++;

  // The engine stalls at random; each accepted frame is matched against the oldest note.
  always @(posedge clock)
    cfg_in_ready <= !rst && ($urandom % 3 != 0);

  always @(posedge clock)
    if (!rst && cfg_in_valid === 1'b1 && cfg_in_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(1'b1, 1'b0, "unexpected frame");
      else
        check(cfg_in_frame, exp_q.pop_front(), "frame content");
    end

  initial
  begin
    void'($urandom(47));
    rst = 1'b1;
    config_mode_straps = 2'h1;
    src_frame = '0;
    src_valid = '0;
    rd_frame = '0;
    rd_valid = 1'b0;
    cfg_in_ready = 1'b0;
    lock_option = 1'b0;
    bitstream_encrypted = 1'b0;
    program_done = 1'b0;
    fork
      i_jtag_host_model.reset_tap();
      repeat (4) @(posedge clock);
    join
    rst <= 1'b0;
    @(posedge clock);
    frame = {$urandom, $urandom, $urandom, $urandom};
    src_frame[`FRAME_WIDTH +: `FRAME_WIDTH] <= frame;
    src_valid[1] <= 1'b1;
    exp_q.push_back(frame);
    wait_for(0);
    src_valid[1] <= 1'b0;
    wait_for(2);
    i_jtag_host_model.scan(1'b0, `ID_WIDTH, '0, dout);
    check(dout[31:0], ID, "identification");
    check(oe_cnt, `ID_WIDTH, "output enable cycles");
    check(tdo_oe, 1'b0, "output enable idle");
    i_jtag_host_model.scan(1'b1, `IR_WIDTH, `OP_BYPASS, dout);
    check(dout[`IR_WIDTH-1:0], `IR_CAPTURE, "instruction capture");
    i_jtag_host_model.scan(1'b0, 8, 129'h5c, dout);
    check(dout[7:0], 8'hb8, "bypass delay");
    i_jtag_host_model.scan(1'b1, `IR_WIDTH, `OP_CFG_WRITE, dout);
    // The override needs two clock edges to cross before the strap source competes.
    repeat (3) @(posedge clock);
    src_valid[1] <= 1'b1;
    repeat (3)
    begin
      frame = {$urandom, $urandom, $urandom, $urandom};
      i_jtag_host_model.scan(1'b0, `FRAME_WIDTH, frame, dout);
      check(dout[0], 1'b0, "write busy");
      exp_q.push_back(frame);
      wait_for(2);
      i_jtag_host_model.idle(8);
    end
    check(jtag_override, 1'b1, "override");
    @(posedge clock);
    src_valid[1] <= 1'b0;
    frame = {$urandom, $urandom, $urandom, $urandom};
    rd_frame <= frame;
    rd_valid <= 1'b1;
    wait_for(1);
    rd_valid <= 1'b0;
    i_jtag_host_model.idle(8);
    i_jtag_host_model.scan(1'b1, `IR_WIDTH, `OP_CFG_READ, dout);
    i_jtag_host_model.scan(1'b0, `READ_DR_WIDTH, '0, dout);
    check(dout, {frame, 1'b1}, "read frame");
    i_jtag_host_model.scan(1'b0, `READ_DR_WIDTH, '0, dout);
    check(dout, 129'h0, "read consumed");
    @(posedge clock);
    lock_option <= 1'b1;
    program_done <= 1'b1;
    bitstream_encrypted <= 1'b1;
    repeat (2) @(posedge clock);
    check(locked, 1'b1, "lock set");
    i_jtag_host_model.scan(1'b1, `IR_WIDTH, `OP_UNLOCK, dout);
    i_jtag_host_model.scan(1'b0, 1, '0, dout);
    repeat (10) @(posedge clock);
    check(locked, 1'b1, "encrypted unlock");
    bitstream_encrypted <= 1'b0;
    i_jtag_host_model.scan(1'b0, 1, '0, dout);
    repeat (10) @(posedge clock);
    check(locked, 1'b0, "unlock");
    report_and_stop;
  end
endmodule

bind jtag_config_frame_path jtag_config_frame_path_chk #(.SOURCES(SOURCES))
  i_jtag_config_frame_path_chk (.clock(clock), .rst(rst), .tck(tck), .trst_n(trst_n),
  .tdo(tdo), .src_valid(src_valid), .src_ack(src_ack), .cfg_in_frame(cfg_in_frame),
  .cfg_in_valid(cfg_in_valid), .cfg_in_ready(cfg_in_ready), .rd_valid(rd_valid),
  .rd_ack(rd_ack), .lock_option(lock_option), .bitstream_encrypted(bitstream_encrypted),
  .program_done(program_done), .locked(locked), .jtag_override(jtag_override));

// File: jtag_host_model.sv
// Behavioural test host that drives the five-pin test port.
// Assumes the test clock stands still low between scans and starts from run_test_idle.
`timescale 1ns/10ps

module jtag_host_model
(
  output logic      tck,
  output logic      trst_n,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  initial
  begin
    tck = 1'b0;
    trst_n = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // Pins change while the clock is low and hold across the rising edge.
  task automatic tick(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #8;
    tck = 1'b1;
    o = tdo;
    #16;
    tck = 1'b0;
    #8;
  endtask

  // Resets the test port only; used once, before any frame is loaded.
  task automatic reset_tap;
    logic o;
    trst_n = 1'b0;
    repeat (5) tick(1'b1, ~tdi, o);
    trst_n = 1'b1;
    tick(1'b0, ~tdi, o);
  endtask

  task automatic idle(input int n);
    logic o;
    repeat (n) tick(1'b0, ~tdi, o);
  endtask

  // Outside shifting the data line toggles, so a stale value is never mistaken for data.
  task automatic scan(input logic is_ir, input int n, input logic [128:0] din,
                      output logic [128:0] dout);
    logic o;
    dout = '0;
    tick(1'b1, ~tdi, o);
    if (is_ir)
      tick(1'b1, ~tdi, o);
    tick(1'b0, ~tdi, o);
    tick(1'b0, ~tdi, o);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    tick(1'b1, ~tdi, o);
    tick(1'b0, ~tdi, o);
  endtask
endmodule
